/* File: rtl/pmtr_defs.vh */
// Constants for the program memory table read unit.
// Assumes inclusion by bare name from the design file.
`ifndef PMTR_DEFS_VH
`define PMTR_DEFS_VH
`define PMTR_WORD_W 16
`define PMTR_ADDR_W 14
`define PMTR_DEPTH_LARGE 16384
`define PMTR_DEPTH_SMALL 8192
`define PMTR_BANK_BIT 13
`define PMTR_RESET_VEC 14'h0000
`define PMTR_DST_W 9
`define PMTR_SECTOR_MSB 8
`define PMTR_SECTOR_ZERO 1'h0
`define PMTR_ST_IDLE 2'h0
`define PMTR_ST_FETCH 2'h1
`define PMTR_ST_DONE 2'h2
`define PMTR_ST_PROG 2'h3
`define PMTR_SH_W 5
`define PMTR_FRAME_BITS 5'h1f
`define PMTR_CMD_WRITE_PM 2'h0
`define PMTR_CMD_READ_PM 2'h1
`define PMTR_CMD_WRITE_EE 2'h2
`define PMTR_CMD_READ_EE 2'h3
`define PMTR_CMD_MSB 31
`define PMTR_CMD_LSB 30
`define PMTR_FADDR_MSB 29
`define PMTR_FADDR_LSB 16
`define PMTR_EE_ADDR_MSB 23
`define PMTR_DATA_MSB 15
`define PMTR_BYTE_MSB 7
`define PMTR_HALF_BITS 5'h0f
`define PMTR_PTR_HI_MSB 5
`endif

/* File: rtl/pmtr_table_read.v */
// Program memory with reset-vector fetch, table reads and a serial programming port.
// Assumes the core issues one table request at a time and waits for done.
`default_nettype none
`include "pmtr_defs.vh"
module pmtr_table_read #(
  parameter LARGE = 1
) (
  input wire core_clk_in,
  input wire reset_in,
  input wire step_in,
  input wire load_in,
  input wire [13:0] target_in,
  output reg [13:0] pc_out,
  output reg [15:0] instr_out,
  output reg bank_out,
  input wire [7:0] tbl_ptr_lo_in,
  input wire [7:0] tbl_ptr_hi_in,
  input wire tbl_req_in,
  input wire ext_table_read_op_in,
  input wire [8:0] tbl_dst_in,
  output reg tbl_busy_out,
  output reg tbl_done_out,
  output reg tbl_we_out,
  output reg [8:0] tbl_waddr_out,
  output reg [7:0] tbl_wdata_out,
  output reg tbl_illegal_out,
  input wire th_we_in,
  input wire [7:0] th_wdata_in,
  output reg [7:0] table_high_latch_out,
  input wire prog_mode_in,
  input wire prog_serial_clk_in,
  input wire prog_serial_io_in,
  output reg prog_serial_io_out,
  output reg prog_serial_io_oe_n_out,
  output reg [7:0] ee_addr_out,
  output reg [7:0] ee_wdata_out,
  output reg ee_we_out,
  input wire [7:0] ee_rdata_in
);
  localparam DEPTH = LARGE ? `PMTR_DEPTH_LARGE : `PMTR_DEPTH_SMALL;

  // Word storage; no reset contents, so unprogrammed words read as unknown
  reg [15:0] mem [0:DEPTH-1];
  reg [1:0] state_r;
  reg [13:0] taddr_r;
  reg [8:0] dst_r;
  reg sck_d_r;
  reg [4:0] cnt_r;
  reg [31:0] sh_r;
  reg [15:0] rd_r;
  reg ee_pend_r;

  wire sck_rise = prog_serial_clk_in & ~sck_d_r;
  wire sck_fall = ~prog_serial_clk_in & sck_d_r;
  wire [31:0] frame = {sh_r[30:0], prog_serial_io_in};
  wire [1:0] cmd_w = frame[`PMTR_CMD_MSB:`PMTR_CMD_LSB];
  wire [13:0] faddr_w = frame[`PMTR_FADDR_MSB:`PMTR_FADDR_LSB];
  wire frame_end = state_r == `PMTR_ST_PROG && sck_rise && cnt_r == `PMTR_FRAME_BITS;

  // Small variant folds the bank bit away so every address stays in range
  function [13:0] pmtr_mask;
    input [13:0] a;
    begin
      pmtr_mask = LARGE ? a : {1'b0, a[`PMTR_BANK_BIT-1:0]};
    end
  endfunction

  // Read commands turn the shared data pin around after the frame
  function pmtr_is_read;
    input [1:0] c;
    begin
      pmtr_is_read = c == `PMTR_CMD_READ_PM || c == `PMTR_CMD_READ_EE;
    end
  endfunction

  // Memory write kept apart from the reset process: arrays take no reset
  always @(posedge core_clk_in) begin
    if (frame_end && cmd_w == `PMTR_CMD_WRITE_PM) begin
      mem[pmtr_mask(faddr_w)] <= frame[`PMTR_DATA_MSB:0];
    end
  end

  // Single clock; reset clears every output flop except the pin enable, which it sets high
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pc_out <= `PMTR_RESET_VEC;
      instr_out <= 16'h0000;
      bank_out <= 1'b0;
      state_r <= `PMTR_ST_IDLE;
      taddr_r <= 14'h0000;
      dst_r <= 9'h000;
      tbl_busy_out <= 1'b0;
      tbl_done_out <= 1'b0;
      tbl_we_out <= 1'b0;
      tbl_waddr_out <= 9'h000;
      tbl_wdata_out <= 8'h00;
      tbl_illegal_out <= 1'b0;
      table_high_latch_out <= 8'h00;
      sck_d_r <= 1'b0;
      cnt_r <= 5'h00;
      sh_r <= 32'h00000000;
      rd_r <= 16'h0000;
      ee_pend_r <= 1'b0;
      prog_serial_io_out <= 1'b0;
      prog_serial_io_oe_n_out <= 1'b1;
      ee_addr_out <= 8'h00;
      ee_wdata_out <= 8'h00;
      ee_we_out <= 1'b0;
    end else begin
      tbl_done_out <= 1'b0;
      tbl_we_out <= 1'b0;
      tbl_illegal_out <= 1'b0;
      ee_we_out <= 1'b0;
      ee_pend_r <= 1'b0;
      sck_d_r <= prog_serial_clk_in;

      // A fetch ending in the same cycle overrides this software write
      if (th_we_in) begin
        table_high_latch_out <= th_wdata_in;
      end

      if (load_in) begin
        pc_out <= pmtr_mask(target_in);
      end else if (step_in && state_r != `PMTR_ST_PROG) begin
        pc_out <= pmtr_mask(pc_out + 14'h0001);
      end
      bank_out <= LARGE ? pc_out[`PMTR_BANK_BIT] : 1'b0;
      instr_out <= mem[pc_out];

      case (state_r)
        `PMTR_ST_IDLE: begin
          if (prog_mode_in) begin
            state_r <= `PMTR_ST_PROG;
            cnt_r <= 5'h00;
            prog_serial_io_oe_n_out <= 1'b1;
          end else if (tbl_req_in) begin
            if (!ext_table_read_op_in &&
                tbl_dst_in[`PMTR_SECTOR_MSB] != `PMTR_SECTOR_ZERO) begin
              tbl_illegal_out <= 1'b1;
              tbl_done_out <= 1'b1;
            end else begin
              taddr_r <= pmtr_mask({tbl_ptr_hi_in[`PMTR_PTR_HI_MSB:0], tbl_ptr_lo_in});
              dst_r <= tbl_dst_in;
              tbl_busy_out <= 1'b1;
              state_r <= `PMTR_ST_FETCH;
            end
          end
        end
        `PMTR_ST_FETCH: begin
          // Pointer inputs are not written back; the core keeps them
          tbl_wdata_out <= mem[taddr_r][7:0];
          table_high_latch_out <= mem[taddr_r][15:8];
          tbl_waddr_out <= dst_r;
          tbl_we_out <= 1'b1;
          tbl_done_out <= 1'b1;
          tbl_busy_out <= 1'b0;
          state_r <= `PMTR_ST_IDLE;
        end
        `PMTR_ST_PROG: begin
          // Pin treated as synchronous; writer alone drives clock
          if (ee_pend_r) begin
            // Data store answers one cycle after the address moves
            rd_r <= {8'h00, ee_rdata_in};
          end
          if (!prog_mode_in) begin
            state_r <= `PMTR_ST_IDLE;
            prog_serial_io_oe_n_out <= 1'b1;
            pc_out <= `PMTR_RESET_VEC;
          end else if (sck_rise) begin
            sh_r <= frame;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == `PMTR_FRAME_BITS) begin
              case (cmd_w)
                `PMTR_CMD_READ_PM: rd_r <= mem[pmtr_mask(faddr_w)];
                `PMTR_CMD_WRITE_EE: begin
                  ee_addr_out <= frame[`PMTR_EE_ADDR_MSB:`PMTR_FADDR_LSB];
                  ee_wdata_out <= frame[`PMTR_BYTE_MSB:0];
                  ee_we_out <= 1'b1;
                end
                `PMTR_CMD_READ_EE: begin
                  ee_addr_out <= frame[`PMTR_EE_ADDR_MSB:`PMTR_FADDR_LSB];
                  ee_pend_r <= 1'b1;
                end
                default: rd_r <= rd_r;
              endcase
              // Read data leaves on falling edges, ahead of the writer's next rise
              prog_serial_io_oe_n_out <= ~pmtr_is_read(cmd_w);
            end else if (cnt_r == `PMTR_HALF_BITS) begin
              // Sixteen rises after a read: hand the pin back to the writer
              prog_serial_io_oe_n_out <= 1'b1;
            end
          end else if (sck_fall && !prog_serial_io_oe_n_out) begin
            prog_serial_io_out <= rd_r[`PMTR_DATA_MSB];
            rd_r <= {rd_r[14:0], 1'b0};
          end
        end
        default: state_r <= `PMTR_ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verification/pmtr_writer_model.sv */
// Serial programming writer: shifts 32-bit frames MSB first.
// Assumes the bench calls send just after a core clock edge.
`default_nettype none
module pmtr_writer_model (
  output logic sclk_out,
  output logic sio_out,
  input wire logic sio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out = 1'b0;
    sio_out = 1'b0;
  end
  // Clock rests low between frames; slow edges suit synchronous pin sampling
  task automatic send(input logic [31:0] f);
    for (int i = 31; i >= 0; i--) begin
      sio_out = f[i];
      #30 sclk_out = 1'b1;
      #30 sclk_out = 1'b0;
    end
    sio_out = ~sio_out;
  endtask
  // Sixteen more rises read back what the device drives after a read frame
  task automatic recv(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      #30 sclk_out = 1'b1;
      w[i] = sio_in;
      #30 sclk_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/pmtr_table_read_monitor.sv */
// Checker for the table read unit, bound to its ports.
// Assumes one core clock and an active-high asynchronous reset.
`default_nettype none
module pmtr_table_read_chk (
  input wire logic core_clk_in, reset_in, tbl_req_in, ext_table_read_op_in, load_in, step_in,
  input wire logic prog_mode_in, th_we_in, tbl_busy_out, tbl_done_out, tbl_we_out,
  input wire logic tbl_illegal_out, ee_we_out,
  input wire logic [8:0] tbl_dst_in, tbl_waddr_out,
  input wire logic [13:0] target_in, pc_out,
  input wire logic [7:0] th_wdata_in, table_high_latch_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_take;
    tbl_req_in && !prog_mode_in && !tbl_busy_out && !tbl_done_out;
  endsequence
  sequence s_ok;
    s_take ##0 (ext_table_read_op_in || !tbl_dst_in[8]);
  endsequence
  sequence s_fin;
    tbl_busy_out ##1 (tbl_done_out && tbl_we_out);
  endsequence
  chk_read_two_cycle: assert property (s_ok |=> s_fin)
    else $error("table read timing");
  chk_dst_addr: assert property (s_ok |=> ##1 tbl_waddr_out == $past(tbl_dst_in, 2))
    else $error("table write address");
  chk_sector_refuse: assert property (s_take ##0 (!ext_table_read_op_in && tbl_dst_in[8])
    |=> tbl_done_out && tbl_illegal_out && !tbl_we_out)
    else $error("sector refusal");
  chk_done_pulse: assert property (tbl_done_out |=> !tbl_done_out)
    else $error("done too long");
  chk_pc_load: assert property (load_in && !prog_mode_in && !$past(prog_mode_in)
    |=> pc_out == $past(target_in))
    else $error("pc load");
  chk_pc_step: assert property (step_in && !load_in && !prog_mode_in && !$past(prog_mode_in)
    |=> pc_out == $past(pc_out) + 14'h0001)
    else $error("pc step");
  chk_th_write: assert property (th_we_in && !tbl_busy_out
    |=> table_high_latch_out == $past(th_wdata_in))
    else $error("latch write");
  chk_reset_vector: assert property ($fell(reset_in) |-> pc_out == 14'h0000)
    else $error("reset vector");
  chk_ee_write_pulse: assert property (ee_we_out |=> !ee_we_out)
    else $error("store write too long");
endmodule
bind pmtr_table_read pmtr_table_read_chk C (.*);
`default_nettype wire

/* File: verification/pmtr_table_read_tb.sv */
// Bench for the table read unit with a serial writer model.
// Assumes a 100 MHz core clock; memory is loaded over the serial port.
`default_nettype none
`define CHK(n, e, a) check_count++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end
module pmtr_table_read_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 0, reset_in = 1, step_in = 0, load_in = 0, tbl_req_in = 0;
  logic ext_table_read_op_in = 0, th_we_in = 0, prog_mode_in = 0, prog_serial_clk_in, sio_w;
  logic prog_serial_io_in, bank_out, tbl_busy_out, tbl_done_out, tbl_we_out, tbl_illegal_out;
  logic prog_serial_io_out, prog_serial_io_oe_n_out, ee_we_out;
  logic [13:0] target_in = 0, pc_out;
  logic [15:0] instr_out;
  logic [8:0] tbl_dst_in = 0, tbl_waddr_out;
  logic [7:0] tbl_ptr_lo_in = 0, tbl_ptr_hi_in = 0, th_wdata_in = 0, table_high_latch_out;
  logic [7:0] tbl_wdata_out, ee_addr_out, ee_wdata_out, ee_rdata_in;
  int errors = 0, check_count = 0, cyc = 0;
  // Shared data wire: device drives only while its enable is low
  assign prog_serial_io_in = prog_serial_io_oe_n_out ? sio_w : prog_serial_io_out;
  // Data store model: a fixed pattern of the address
  assign ee_rdata_in = ee_addr_out ^ 8'h5a;
  pmtr_table_read DUT (.*);
  pmtr_writer_model W (.sclk_out(prog_serial_clk_in), .sio_out(sio_w), .sio_in(prog_serial_io_in));
  initial forever #5 core_clk_in = ~core_clk_in;
  task end_of_test;
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk_in) if (++cyc == 20000) begin errors++; end_of_test; end
  task tick(input int n); repeat (n) @(posedge core_clk_in); #1; endtask
  task t_prog;
    prog_mode_in = 1;
    W.send({2'h0, 14'h1f06, 16'h5a1a});
    W.send({2'h0, 14'h3f05, 16'ha50f});
    W.send({2'h0, 14'h0000, 16'hc3e1});
    W.send({2'h2, 14'h0033, 16'h0077});
    tick(2);
    `CHK("ee_addr", 8'h33, ee_addr_out)
    `CHK("ee_data", 8'h77, ee_wdata_out)
    prog_mode_in = 0;
    tick(2);
    `CHK("pc", 14'h0000, pc_out)
    `CHK("instr", 16'hc3e1, instr_out)
  endtask
  task t_rd(input logic e, input logic [8:0] d, input logic [13:0] a, input logic [15:0] w);
    ext_table_read_op_in = e;
    tbl_dst_in = d;
    {tbl_ptr_hi_in, tbl_ptr_lo_in} = {2'b00, a};
    tbl_req_in = 1;
    tick(1);
    tbl_req_in = 0;
    `CHK("busy", 1'b1, tbl_busy_out)
    tick(1);
    `CHK("we", 1'b1, tbl_we_out)
    `CHK("done", 1'b1, tbl_done_out)
    `CHK("waddr", d, tbl_waddr_out)
    `CHK("wdata", w[7:0], tbl_wdata_out)
    `CHK("high", w[15:8], table_high_latch_out)
  endtask
  task t_rb(input logic [31:0] f, input logic [15:0] x);
    logic [15:0] got;
    prog_mode_in = 1;
    tick(1);
    W.send(f);
    W.recv(got);
    tick(2);
    `CHK("readback", x, got)
    `CHK("pin_free", 1'b1, prog_serial_io_oe_n_out)
    prog_mode_in = 0;
    tick(2);
  endtask
  task t_reset;
    load_in = 1;
    target_in = 14'h0123;
    tick(1);
    load_in = 0;
    `CHK("pc_before", 14'h0123, pc_out)
    reset_in = 1;
    tick(1);
    reset_in = 0;
    `CHK("pc_reset", 14'h0000, pc_out)
    tick(2);
    `CHK("instr_reset", 16'hc3e1, instr_out)
    `CHK("latch_reset", 8'h00, table_high_latch_out)
  endtask
  task t_misc;
    tbl_dst_in = 9'h120;
    ext_table_read_op_in = 0;
    tbl_req_in = 1;
    tick(1);
    tbl_req_in = 0;
    `CHK("illegal", 1'b1, tbl_illegal_out)
    `CHK("no_we", 1'b0, tbl_we_out)
    th_we_in = 1;
    th_wdata_in = 8'h3c;
    tick(1);
    th_we_in = 0;
    `CHK("th", 8'h3c, table_high_latch_out)
    load_in = 1;
    target_in = 14'h3ffe;
    tick(1);
    load_in = 0;
    step_in = 1;
    `CHK("pc_load", 14'h3ffe, pc_out)
    tick(1);
    `CHK("bank", 1'b1, bank_out)
    tick(1);
    step_in = 0;
    `CHK("pc_wrap", 14'h0000, pc_out)
  endtask
  initial begin
    tick(3);
    reset_in = 0;
    t_prog;
    t_rb({2'h1, 14'h1f06, 16'h0000}, 16'h5a1a);
    t_rb({2'h3, 14'h0033, 16'h0000}, 16'h0069);
    t_rd(1'b0, 9'h012, 14'h1f06, 16'h5a1a);
    t_rd(1'b1, 9'h145, 14'h3f05, 16'ha50f);
    tick(1);
    t_misc;
    t_reset;
    end_of_test;
  end
endmodule
`default_nettype wire
